// ### verilog/commutation_defines.svh
// constants of the commutation pwm block
`ifndef COMMUTATION_DEFINES_SVH
`define COMMUTATION_DEFINES_SVH

// ---------------------------------------------------------------
// mode field encoding
// ---------------------------------------------------------------
`define MODE_IDLE 2'h0
`define MODE_RIGHT 2'h1
`define MODE_LEFT 2'h2
`define MODE_SLOW 2'h3

// ---------------------------------------------------------------
// phase kinds
// ---------------------------------------------------------------
`define PH_BLOCK 2'h0
`define PH_FOUR 2'h1
`define PH_FIVE 2'h2
`define PH_SIX 2'h3

// ---------------------------------------------------------------
// output pattern bit positions: cc0..cc2 then cout0..cout2
// ---------------------------------------------------------------
`define POS_CC0 0
`define POS_CC1 1
`define POS_CC2 2
`define POS_CO0 3
`define POS_CO1 4
`define POS_CO2 5

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_STATE 3'h0
`define RST_PAT 6'h00
`define RST_POS 3'h0

`endif

// ### verilog/commutation_pkg.sv
// types of the commutation pwm block
package commutation_pkg;
	typedef logic [5:0] pattern_t;
	typedef logic [2:0] phase_state_t;
	typedef enum logic [3:0] {
		ST_RUN = 4'h1,
		ST_IDLE = 4'h2,
		ST_HOLD = 4'h4,
		ST_SPARE = 4'h8
	} ctl_state_e;
endpackage : commutation_pkg

// ### verilog/pattern_if.sv
// active pattern carried from the sequencer to the output stage
`timescale 1ns/100ps
`default_nettype none
interface pattern_if;
	import commutation_pkg::*;
	pattern_t active;
	modport src (output active);
	modport dst (input active);
endinterface : pattern_if
`default_nettype wire

// ### verilog/phase_output_stage.sv
// output stage: inactive levels and modulation of active phases
`timescale 1ns/100ps
`default_nettype none
`include "commutation_defines.svh"
module phase_output_stage
	import commutation_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// pattern in
	pattern_if.dst pat,
	// configuration
	input wire logic [5:0] inactive_level_reg,
	input wire logic [5:0] burst_modulation_select,
	input wire logic [5:0] timer_one_mod_enable,
	input wire logic compare_timer_one,
	input wire logic compare_timer_two,
	// pins
	output logic [5:0] pins_q
);

	function automatic logic drive(input logic act, input logic lvl, input logic m1,
		input logic m2, input logic t1, input logic t2);
		logic a;
		a = 1'b1;
		if (m1)
			a = t1;
		if (m2)
			a = a & t2;
		drive = act ? (a ? ~lvl : lvl) : lvl;
	endfunction : drive

	// ---------------------------------------------------------------
	// registered pins
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pins_q <= `RST_PAT;
		end else begin
			for (int i = 0; i < 6; i++) begin
				pins_q[i] <= drive(pat.active[i], inactive_level_reg[i],
					timer_one_mod_enable[i], burst_modulation_select[i],
					compare_timer_one, compare_timer_two);
			end
		end
	end

	a_inactive_level: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!pat.active[0] |=> pins_q[0] == $past(inactive_level_reg[0]))
		else $error("inactive phase not at inactive level");
	a_static_active: assert property (@(posedge clk_sys) disable iff (!reset_n)
		pat.active[3] && !timer_one_mod_enable[3] && !burst_modulation_select[3]
		|=> pins_q[3] == !$past(inactive_level_reg[3]))
		else $error("static active phase wrong");

endmodule : phase_output_stage
`default_nettype wire

// ### verilog/position_sampler.sv
// samples the rotor position pins and reports transitions
`timescale 1ns/100ps
`default_nettype none
`include "commutation_defines.svh"
module position_sampler (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// pins
	input wire logic [2:0] rotor_position_inputs,
	// results
	output logic [2:0] pos_q,
	output logic [2:0] prev_q,
	output logic changed_q
);

	logic primed_q;

	// ---------------------------------------------------------------
	// one sample per cycle
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pos_q <= `RST_POS;
			prev_q <= `RST_POS;
			changed_q <= 1'b0;
			primed_q <= 1'b0;
		end else begin
			pos_q <= rotor_position_inputs;
			// first sample after reset is no edge: no false capture or interrupt
			prev_q <= primed_q ? pos_q : rotor_position_inputs;
			changed_q <= primed_q && (rotor_position_inputs != pos_q);
			primed_q <= 1'b1;
		end
	end

	a_change_seen: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(primed_q) && pos_q != $past(pos_q) |-> changed_q)
		else $error("position change missed");

endmodule : position_sampler
`default_nettype wire

// ### verilog/multi_channel_commutation_pwm.sv
// block commutation and multi-phase pwm sequencer, top level
// Operation
// - sample position pins every clock
// - position change updates all six outputs
// - rotate left block commutation table
// - rotate right block commutation table
// - slow down and idle fixed patterns
// - all-low or all-high position in rotate left or right mode sets error, idle
// - error with enable raises emergency request
// - wrong follower with check enabled forces idle
// - idle entry sets error; software clears
// - block mode forces channel zero capture
// - any position edge in block mode gives capture pulse
// - edge-configured interrupts still raised
// - four-phase output pattern table
// - four-phase follower table
// - five-phase output pattern table
// - five-phase follower table
// - six-phase output pattern table
// - six-phase follower table
// - inactive phase drives inactive level bit
// - active phase static or timer modulated
// - multi-phase step on timer one zero
// - mode field encoding idle right left slow
`timescale 1ns/100ps
`default_nettype none
`include "commutation_defines.svh"
module multi_channel_commutation_pwm
	import commutation_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// position sensors
	input wire logic [2:0] rotor_position_inputs,
	// control
	input wire logic commutation_mode_hi,
	input wire logic commutation_mode_lo,
	input wire logic [1:0] phase_kind,
	input wire logic follower_check_enable,
	input wire logic error_clear,
	input wire logic emergency_enable,
	input wire logic [2:0] ext_int_rise_enable,
	input wire logic [2:0] ext_int_fall_enable,
	// modulation
	input wire logic [5:0] inactive_level_reg,
	input wire logic [5:0] burst_modulation_select,
	input wire logic [5:0] timer_one_mod_enable,
	input wire logic compare_timer_one,
	input wire logic compare_timer_two,
	input wire logic timer_one_zero,
	// outputs
	output logic [2:0] capcom_outputs,
	output logic [2:0] complementary_compare_outputs,
	output logic commutation_error_flag,
	output logic emergency_irq_q,
	output logic capture_mode_q,
	output logic capture_pulse_q,
	output logic [2:0] ext_int_req_q,
	output logic [2:0] phase_state_q
);

	logic [2:0] pos;
	logic [2:0] prev;
	logic changed;
	logic [1:0] mode;
	logic block_mode;
	logic err_q;
	phase_state_t state_q;
	phase_state_t state_d;
	pattern_t pat_q;
	pattern_t pat_d;
	ctl_state_e ctl_q;
	logic [5:0] pins;
	logic illegal;
	logic wrong_follow;
	logic [2:0] last_legal_q;
	logic go_idle;

	pattern_if pif ();
	assign mode = {commutation_mode_hi, commutation_mode_lo};
	assign block_mode = (phase_kind == `PH_BLOCK);

	// ---------------------------------------------------------------
	// lookup functions
	// ---------------------------------------------------------------
	function automatic pattern_t bit2(input int a, input int b);
		pattern_t p;
		p = '0;
		p[a] = 1'b1;
		p[b] = 1'b1;
		bit2 = p;
	endfunction : bit2

	// position given as {in0,in1,in2}
	function automatic pattern_t block_pat(input logic [1:0] m, input logic [2:0] p);
		case (m)
			`MODE_LEFT: begin
				case (p)
					3'h5: block_pat = bit2(`POS_CC2, `POS_CO0);
					3'h4: block_pat = bit2(`POS_CC1, `POS_CO0);
					3'h6: block_pat = bit2(`POS_CC1, `POS_CO2);
					3'h2: block_pat = bit2(`POS_CC0, `POS_CO2);
					3'h3: block_pat = bit2(`POS_CC0, `POS_CO1);
					3'h1: block_pat = bit2(`POS_CC2, `POS_CO1);
					default: block_pat = '0;
				endcase
			end
			`MODE_RIGHT: begin
				case (p)
					3'h6: block_pat = bit2(`POS_CC0, `POS_CO1);
					3'h4: block_pat = bit2(`POS_CC0, `POS_CO2);
					3'h5: block_pat = bit2(`POS_CC1, `POS_CO2);
					3'h1: block_pat = bit2(`POS_CC1, `POS_CO0);
					3'h3: block_pat = bit2(`POS_CC2, `POS_CO0);
					3'h2: block_pat = bit2(`POS_CC2, `POS_CO1);
					default: block_pat = '0;
				endcase
			end
			`MODE_SLOW: block_pat = 6'h38;
			default: block_pat = '0;
		endcase
	endfunction : block_pat

	// legal next position in a rotate sequence
	function automatic logic [2:0] block_next(input logic [1:0] m, input logic [2:0] p);
		case (p)
			3'h5: block_next = (m == `MODE_LEFT) ? 3'h4 : 3'h1;
			3'h4: block_next = (m == `MODE_LEFT) ? 3'h6 : 3'h5;
			3'h6: block_next = (m == `MODE_LEFT) ? 3'h2 : 3'h4;
			3'h2: block_next = (m == `MODE_LEFT) ? 3'h3 : 3'h6;
			3'h3: block_next = (m == `MODE_LEFT) ? 3'h1 : 3'h2;
			3'h1: block_next = (m == `MODE_LEFT) ? 3'h5 : 3'h3;
			default: block_next = 3'h0;
		endcase
	endfunction : block_next

	function automatic pattern_t phase_pat(input logic [1:0] k, input phase_state_t s);
		case (k)
			`PH_FOUR: begin
				case (s)
					3'h1: phase_pat = bit2(`POS_CC0, `POS_CO2);
					3'h2: phase_pat = bit2(`POS_CC0, `POS_CO1);
					3'h3: phase_pat = bit2(`POS_CO1, `POS_CC2);
					3'h4: phase_pat = bit2(`POS_CC2, `POS_CO2);
					3'h5: phase_pat = bit2(`POS_CO1, `POS_CO2);
					default: phase_pat = '0;
				endcase
			end
			`PH_FIVE: begin
				case (s)
					3'h1: phase_pat = bit2(`POS_CC0, `POS_CO2);
					3'h2: phase_pat = bit2(`POS_CC0, `POS_CO1);
					3'h3: phase_pat = bit2(`POS_CO1, `POS_CC2);
					3'h4: phase_pat = bit2(`POS_CC2, `POS_CO0);
					3'h5: phase_pat = bit2(`POS_CO0, `POS_CO2);
					3'h6: phase_pat = 6'h38;
					default: phase_pat = '0;
				endcase
			end
			`PH_SIX: begin
				case (s)
					3'h1: phase_pat = bit2(`POS_CC0, `POS_CO1);
					3'h2: phase_pat = bit2(`POS_CO1, `POS_CC2);
					3'h3: phase_pat = bit2(`POS_CC2, `POS_CO0);
					3'h4: phase_pat = bit2(`POS_CO0, `POS_CC1);
					3'h5: phase_pat = bit2(`POS_CC1, `POS_CO2);
					3'h6: phase_pat = bit2(`POS_CC0, `POS_CO2);
					3'h7: phase_pat = 6'h38;
					default: phase_pat = '0;
				endcase
			end
			default: phase_pat = '0;
		endcase
	endfunction : phase_pat

	// follower tables; last is the slow-down state of the kind
	function automatic phase_state_t follower(input logic [1:0] k, input logic [1:0] m,
		input phase_state_t s);
		phase_state_t last;
		last = (k == `PH_FOUR) ? 3'h5 : (k == `PH_FIVE) ? 3'h6 : 3'h7;
		case (m)
			`MODE_IDLE: follower = 3'h0;
			`MODE_SLOW: follower = last;
			`MODE_LEFT: follower = (s == 3'h0 || s >= last - 3'h1) ? 3'h1 : s + 3'h1;
			`MODE_RIGHT: begin
				// state 1 falls back to 4 in four-phase, to 5 in five and six
				if (s == 3'h0 || s == last)
					follower = 3'h2;
				else
					follower = (s == 3'h1) ? ((k == `PH_FOUR) ? 3'h4 : 3'h5) : s - 3'h1;
			end
			default: follower = 3'h0;
		endcase
	endfunction : follower

	// ---------------------------------------------------------------
	// position sampling
	// ---------------------------------------------------------------
	position_sampler u_sampler (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.rotor_position_inputs(rotor_position_inputs),
		.pos_q(pos),
		.prev_q(prev),
		.changed_q(changed)
	);

	// ---------------------------------------------------------------
	// fault detection
	// ---------------------------------------------------------------
	assign illegal = block_mode && (mode == `MODE_LEFT || mode == `MODE_RIGHT) &&
		(pos == 3'h0 || pos == 3'h7);
	assign wrong_follow = block_mode && follower_check_enable && changed &&
		(mode == `MODE_LEFT || mode == `MODE_RIGHT) && last_legal_q != 3'h0 &&
		pos != block_next(mode, last_legal_q);
	assign go_idle = (ctl_q == ST_RUN) && (illegal || wrong_follow);

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			last_legal_q <= 3'h0;
		end else if (!block_mode || ctl_q != ST_RUN) begin
			last_legal_q <= 3'h0;
		end else if (changed && !illegal && !wrong_follow) begin
			last_legal_q <= pos;
		end
	end

	// ---------------------------------------------------------------
	// control state and error flag
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ctl_q <= ST_RUN;
		end else begin
			case (ctl_q)
				ST_RUN: if (go_idle) ctl_q <= ST_IDLE;
				ST_IDLE: if (error_clear && !err_q) ctl_q <= ST_RUN;
				default: ctl_q <= ST_IDLE;
			endcase
		end
	end

	// set wins over software clear
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			err_q <= 1'b0;
		end else if (go_idle) begin
			err_q <= 1'b1;
		end else if (error_clear) begin
			err_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			emergency_irq_q <= 1'b0;
		end else begin
			emergency_irq_q <= (err_q || go_idle) && emergency_enable;
		end
	end

	// ---------------------------------------------------------------
	// capture channel zero and edge interrupts
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			capture_mode_q <= 1'b0;
			capture_pulse_q <= 1'b0;
			ext_int_req_q <= 3'h0;
		end else begin
			capture_mode_q <= block_mode;
			capture_pulse_q <= block_mode && changed;
			ext_int_req_q <= (ext_int_rise_enable & pos & ~prev) |
				(ext_int_fall_enable & ~pos & prev);
		end
	end

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		pat_d = pat_q;
		if (ctl_q != ST_RUN || go_idle) begin
			state_d = `RST_STATE;
			pat_d = `RST_PAT;
		end else if (block_mode) begin
			pat_d = block_pat(mode, pos);
		end else begin
			if (timer_one_zero)
				state_d = follower(phase_kind, mode, state_q);
			pat_d = phase_pat(phase_kind, state_d);
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= `RST_STATE;
			pat_q <= `RST_PAT;
		end else begin
			state_q <= state_d;
			pat_q <= pat_d;
		end
	end

	assign pif.active = pat_q;
	phase_output_stage u_out (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.pat(pif.dst),
		.inactive_level_reg(inactive_level_reg),
		.burst_modulation_select(burst_modulation_select),
		.timer_one_mod_enable(timer_one_mod_enable),
		.compare_timer_one(compare_timer_one),
		.compare_timer_two(compare_timer_two),
		.pins_q(pins)
	);

	assign capcom_outputs = pins[2:0];
	assign complementary_compare_outputs = pins[5:3];
	assign commutation_error_flag = err_q;
	assign phase_state_q = state_q;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_illegal_sets_err: assert property (@(posedge clk_sys) disable iff (!reset_n)
		illegal && ctl_q == ST_RUN |=> err_q && ctl_q == ST_IDLE)
		else $error("illegal position not trapped");
	a_idle_holds: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctl_q == ST_IDLE && err_q |=> ctl_q == ST_IDLE)
		else $error("idle left with error set");
	a_idle_zero_pat: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctl_q == ST_IDLE |=> pat_q == 6'h00)
		else $error("idle pattern not inactive");
	a_slow_pattern: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctl_q == ST_RUN && !go_idle && block_mode && mode == `MODE_SLOW
		|=> pat_q == 6'h38)
		else $error("slow down pattern wrong");
	a_left_101: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctl_q == ST_RUN && !go_idle && block_mode && mode == `MODE_LEFT && pos == 3'h5
		|=> pat_q == 6'h0c)
		else $error("rotate left 101 wrong");
	a_right_110: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctl_q == ST_RUN && !go_idle && block_mode && mode == `MODE_RIGHT && pos == 3'h6
		|=> pat_q == 6'h11)
		else $error("rotate right 110 wrong");
	a_capture_edge: assert property (@(posedge clk_sys) disable iff (!reset_n)
		block_mode && changed |=> capture_pulse_q)
		else $error("capture pulse missing");
	a_irq_follows: assert property (@(posedge clk_sys) disable iff (!reset_n)
		err_q && emergency_enable |=> emergency_irq_q)
		else $error("emergency request missing");
	a_four_right: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctl_q == ST_RUN && !go_idle && phase_kind == `PH_FOUR && mode == `MODE_RIGHT
		&& timer_one_zero && state_q == 3'h1 |=> state_q == 3'h4)
		else $error("four phase follower wrong");
	a_six_left: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctl_q == ST_RUN && !go_idle && phase_kind == `PH_SIX && mode == `MODE_LEFT
		&& timer_one_zero && state_q == 3'h6 |=> state_q == 3'h1)
		else $error("six phase follower wrong");
	a_hold_no_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctl_q == ST_RUN && !go_idle && !block_mode && !timer_one_zero
		|=> $stable(state_q))
		else $error("state moved without timer zero");

endmodule : multi_channel_commutation_pwm
`default_nettype wire

// ### bench/rotor_sensor_model.sv
// behavioural rotor position sensor set on the three position pins
`timescale 1ns/100ps
`default_nettype none
module rotor_sensor_model (
	// clock
	input wire logic clk_sys,
	// commanded rotor position
	input wire logic [2:0] target_pos,
	// sensor pins
	output logic [2:0] rotor_position_inputs
);
	// sensors switch between clock edges, never at the sampling edge
	initial rotor_position_inputs = 3'h0;
	always @(negedge clk_sys) begin
		rotor_position_inputs <= target_pos;
	end
endmodule : rotor_sensor_model
`default_nettype wire

// ### bench/multi_channel_commutation_pwm_test.sv
// self-checking bench of the commutation pwm block
`timescale 1ns/100ps
`default_nettype none
`include "commutation_defines.svh"
module multi_channel_commutation_pwm_test
	import commutation_pkg::*;
;
	// ---------------------------------------------------------------
	// expected tables
	// ---------------------------------------------------------------
	// first index: 0 right, 1 left; entry 0 is where each walk starts
	localparam logic [2:0] bpos [2][6] = '{'{3'h3, 3'h2, 3'h6, 3'h4, 3'h5, 3'h1},
		'{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1}};
	localparam logic [5:0] bpat [2][6] = '{'{6'h0c, 6'h14, 6'h11, 6'h21, 6'h22, 6'h0a},
		'{6'h0c, 6'h0a, 6'h22, 6'h21, 6'h11, 6'h14}};
	localparam logic [5:0] mpat [3][8] = '{
		'{6'h00, 6'h21, 6'h11, 6'h14, 6'h24, 6'h30, 6'h00, 6'h00},
		'{6'h00, 6'h21, 6'h11, 6'h14, 6'h0c, 6'h28, 6'h38, 6'h00},
		'{6'h00, 6'h11, 6'h14, 6'h0c, 6'h0a, 6'h22, 6'h21, 6'h38}};
	// first index: 0 right, 1 left
	localparam logic [2:0] fol [2][3][8] = '{
		'{'{3'h2, 3'h4, 3'h1, 3'h2, 3'h3, 3'h2, 3'h0, 3'h0},
		'{3'h2, 3'h5, 3'h1, 3'h2, 3'h3, 3'h4, 3'h2, 3'h0},
		'{3'h2, 3'h5, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h2}},
		'{'{3'h1, 3'h2, 3'h3, 3'h4, 3'h1, 3'h1, 3'h0, 3'h0},
		'{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h1, 3'h1, 3'h0},
		'{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h1, 3'h1}}};
	localparam logic [1:0] mtab [4] = '{`MODE_RIGHT, `MODE_LEFT, `MODE_SLOW, `MODE_IDLE};
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic clk_sys = 1'b0, reset_n = 1'b0, mode_hi = 1'b0, mode_lo = 1'b0;
	logic fce = 1'b0, error_clear = 1'b0, em_en = 1'b1, ct1 = 1'b0, ct2 = 1'b0, tz = 1'b0;
	logic [1:0] phase_kind = `PH_BLOCK;
	logic [2:0] target_pos = 3'h0, rotor_position_inputs, ext_int_req_q, phase_state_q;
	logic [5:0] inact = 6'h3f, bsel = 6'h00, t1en = 6'h00;
	logic [2:0] capcom_outputs, complementary_compare_outputs;
	logic commutation_error_flag, emergency_irq_q, capture_mode_q, capture_pulse_q;
	logic [2:0] st, rise_en = 3'h6, fall_en = 3'h3;
	int n_errors = 0, n_checks = 0, n_cap = 0, n_rise = 0, exp_cap = 0, exp_rise = 0;
	int cycles = 0;
	rotor_sensor_model sensors (.clk_sys(clk_sys), .target_pos(target_pos),
		.rotor_position_inputs(rotor_position_inputs));
	multi_channel_commutation_pwm DUT (.clk_sys(clk_sys), .reset_n(reset_n),
		.rotor_position_inputs(rotor_position_inputs), .commutation_mode_hi(mode_hi),
		.commutation_mode_lo(mode_lo), .phase_kind(phase_kind), .follower_check_enable(fce),
		.error_clear(error_clear), .emergency_enable(em_en), .ext_int_rise_enable(rise_en),
		.ext_int_fall_enable(fall_en), .inactive_level_reg(inact), .burst_modulation_select(bsel),
		.timer_one_mod_enable(t1en), .compare_timer_one(ct1), .compare_timer_two(ct2),
		.timer_one_zero(tz), .capcom_outputs(capcom_outputs),
		.complementary_compare_outputs(complementary_compare_outputs),
		.commutation_error_flag(commutation_error_flag), .emergency_irq_q(emergency_irq_q),
		.capture_mode_q(capture_mode_q), .capture_pulse_q(capture_pulse_q),
		.ext_int_req_q(ext_int_req_q), .phase_state_q(phase_state_q));
	// ---------------------------------------------------------------
	// clock, monitors, timeout
	// ---------------------------------------------------------------
	initial begin
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (capture_pulse_q === 1'b1) n_cap++;
		n_rise += $countones(ext_int_req_q);
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			summarize();
		end
	end
	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : summarize
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : tick
	task automatic do_reset();
		reset_n = 1'b0;
		tick(20);
		reset_n = 1'b1;
		tick(2);
	endtask : do_reset
	task automatic set_mode(input logic [1:0] m);
		{mode_hi, mode_lo} = m;
		tick(3);
	endtask : set_mode
	// pin edges are booked here so capture and interrupt counts can be predicted
	task automatic set_pos(input logic [2:0] p);
		if (p != target_pos) exp_cap++;
		exp_rise += $countones(rise_en & p & ~target_pos);
		exp_rise += $countones(fall_en & ~p & target_pos);
		target_pos = p;
		tick(4);
	endtask : set_pos
	task automatic clear_err();
		// held for three cycles: the flag must be seen low while clear is high
		error_clear = 1'b1;
		tick(3);
		error_clear = 1'b0;
		tick(1);
	endtask : clear_err
	task automatic check_pins(input logic [5:0] pat);
		logic [5:0] gate;
		gate = (~t1en | {6{ct1}}) & (~bsel | {6{ct2}});
		check({2'h0, complementary_compare_outputs, capcom_outputs}, {2'h0, inact ^ (pat & gate)});
	endtask : check_pins
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		do_reset();
		check({5'h0, phase_state_q}, 8'h00);
		check_pins(6'h00);
		check({7'h0, commutation_error_flag}, 8'h00);
		// legal position first, so entering a rotate mode is not a fault
		set_pos(3'h5);
		for (int d = 1; d >= 0; d--) begin
			fce = (d == 1);
			set_mode(d == 1 ? `MODE_LEFT : `MODE_RIGHT);
			for (int i = 1; i <= 6; i++) begin
				set_pos(bpos[d][i % 6]);
				check_pins(bpat[d][i % 6]);
			end
			check({7'h0, capture_mode_q}, 8'h01);
			check({7'h0, commutation_error_flag}, 8'h00);
			if (d == 1) begin
				inact = 6'h15;
				t1en = 6'h07;
				bsel = 6'h38;
				for (int k = 0; k < 4; k++) begin
					{ct2, ct1} = k[1:0];
					tick(3);
					check_pins(6'h0c);
				end
				inact = 6'h3f;
				t1en = 6'h00;
				bsel = 6'h00;
				set_pos(3'h3);
				check({7'h0, commutation_error_flag}, 8'h01);
				check_pins(6'h00);
				clear_err();
				set_pos(3'h2);
				check_pins(6'h21);
				for (int f = 0; f < 2; f++) begin
					set_pos(f == 0 ? 3'h0 : 3'h7);
					check({7'h0, commutation_error_flag}, 8'h01);
					check_pins(6'h00);
					check({7'h0, emergency_irq_q}, 8'h01);
					em_en = 1'b0;
					set_pos(3'h1);
					check({7'h0, emergency_irq_q}, 8'h00);
					em_en = 1'b1;
					tick(10);
					check({7'h0, commutation_error_flag}, 8'h01);
					check_pins(6'h00);
					clear_err();
					set_pos(3'h3);
					check_pins(6'h11);
				end
			end
		end
		set_mode(`MODE_SLOW);
		check_pins(6'h38);
		set_pos(3'h1);
		check_pins(6'h38);
		set_mode(`MODE_IDLE);
		check_pins(6'h00);
		check(8'(n_cap), 8'(exp_cap));
		check(8'(n_rise), 8'(exp_rise));
		// multi-phase: a legal position keeps the block fault path quiet
		set_pos(3'h5);
		for (int k = 1; k < 4; k++) begin
			for (int d = 0; d < 4; d++) begin
				if (d < 3) begin
					{mode_hi, mode_lo} = `MODE_IDLE;
					do_reset();
					st = 3'h0;
				end
				phase_kind = k[1:0];
				set_mode(mtab[d]);
				for (int s = 0; s < 9; s++) begin
					tz = 1'b1;
					tick(1);
					tz = 1'b0;
					tick(3);
					st = (d < 2) ? fol[d][k - 1][st] : (d == 2) ? 3'(k + 4) : 3'h0;
					check({5'h0, phase_state_q}, {5'h0, st});
					check_pins(mpat[k - 1][st]);
				end
			end
		end
		summarize();
	end
endmodule : multi_channel_commutation_pwm_test
`default_nettype wire
